// [include/ppfs_params.svh]
// Purpose: Constants for the port pin function select block
// Assumes: Eight port lines, lines 0..6 two-way, line 7 input only
// Notes:   Definitions only
`ifndef PPFS_PARAMS_SVH
`define PPFS_PARAMS_SVH

// Count of two-way lines and of all lines
`define PPFS_IO_LINES      7
`define PPFS_ALL_LINES     8

// Line positions of the shared functions
`define PPFS_LINE_TONE_P   0
`define PPFS_LINE_TONE_N   1
`define PPFS_LINE_CNT_1ST  2
`define PPFS_LINE_IRQ      3
`define PPFS_LINE_CNT_2ND  4
`define PPFS_LINE_OSC_OUT  5
`define PPFS_LINE_OSC_IN   6
`define PPFS_LINE_INIT     7

// Reset values of the registered outputs
`define PPFS_RST_IO        7'h00
`define PPFS_RST_ALL       8'h00
`define PPFS_RST_HIGH      1'h1
`define PPFS_RST_LOW       1'h0

`endif

// [include/ppfs_pkg.sv]
// Purpose: Types for the port pin function select block
// Assumes: ppfs_params.svh gives the line counts
// Notes:   Encodings of the configuration options live here
`include "ppfs_params.svh"

package ppfs_pkg;

  // Configuration capture phase
  typedef enum logic [0:0] {
    PPFS_LOAD = 1'b0,
    PPFS_RUN  = 1'b1
  } ppfs_phase_type;

  // Oscillator pin arrangement option
  typedef enum logic [1:0] {
    PPFS_OSC_RC_IO  = 2'b00,
    PPFS_OSC_XTAL   = 2'b01,
    PPFS_OSC_RC_RTC = 2'b10,
    PPFS_OSC_EXT_RC = 2'b11
  } ppfs_osc_type;

  // Internal RC nominal frequency option (12, 8 or 4 MHz)
  typedef enum logic [1:0] {
    PPFS_FREQ_4M  = 2'b00,
    PPFS_FREQ_8M  = 2'b01,
    PPFS_FREQ_12M = 2'b10
  } ppfs_freq_type;

  // Whole registered state of the top module
  typedef struct packed {
    ppfs_phase_type                 phase;
    ppfs_osc_type                   osc;
    logic                           rst_pin;
    ppfs_freq_type                  freq;
    logic                           rc_en;
    logic [1:0]                     osc_own;
    logic [`PPFS_IO_LINES-1:0]      pad_out;
    logic [`PPFS_IO_LINES-1:0]      pad_oe;
    logic [`PPFS_IO_LINES-1:0]      pull;
    logic [`PPFS_ALL_LINES-1:0]     rd;
    logic [`PPFS_ALL_LINES-1:0]     prev;
    logic                           wake;
    logic                           cnt_1st;
    logic                           cnt_2nd;
    logic                           irq_n;
    logic                           init_n;
    logic                           clk_in;
  } ppfs_state_type;

endpackage

// [rtl/ppfs_line_cell.sv]
// Purpose: Driver, pull and wake gating of one two-way port line
// Assumes: Purely combinational; the caller registers the results
// Notes:   Oscillator ownership overrides every port use of the line
`timescale 1ns/10ps

module ppfs_line_cell (
  input  wire logic dir_in_i,    // High: line is a Schmitt input
  input  wire logic data_i,      // Software output latch
  input  wire logic pull_req_i,  // Software pull-high bit
  input  wire logic wake_req_i,  // Software wake-up bit
  input  wire logic alt_en_i,    // Shared output function active
  input  wire logic alt_val_i,   // Value of the shared output function
  input  wire logic osc_own_i,   // Line given to the oscillator
  input  wire logic run_i,       // Configuration has been captured
  output logic      oe_o,        // Output driver enable
  output logic      out_o,       // Output level
  output logic      pull_o,      // Pull-high switch
  output logic      wake_arm_o   // Line may wake the core
);

  // Gate shared by the enable, pull and wake paths: idle until configured, off when owned
  logic usable;
  assign usable = run_i & ~osc_own_i;

  // output or input
  // Push-pull driver only when software picks the output direction
  assign oe_o = usable & ~dir_in_i;

  // Shared function replaces the latch value while it is enabled
  assign out_o = alt_en_i ? alt_val_i : data_i;

  // oscillator isolation
  // Pull only from its own bit; never on an oscillator pin
  assign pull_o = usable & pull_req_i;

  assign wake_arm_o = usable & wake_req_i;

endmodule

// [rtl/ppfs_port_pin_select.sv]
// Purpose: Pin function and I/O configuration of an eight-line port
// Assumes: Inputs synchronous to sys_clk_i; options steady after reset
// Notes:   Summary of operation follows
// Summary of operation
// - Lines 0 to 6: push-pull output or Schmitt input
// - Per-line bit enables wake from power-down
// - Pull-high only when its bit is set
// - Lines 0 and 1 drive complementary tone
// - Line 2 feeds first counter input
// - Line 3 is active-low interrupt, still I/O
// - Line 4 feeds second counter input
// - Option maps lines 5 and 6 to oscillator
// - Internal RC selects 12, 8 or 4 MHz
// - Line 7: reset input or input only
`timescale 1ns/10ps

// Line counts and positions, guarded against double inclusion
`include "ppfs_params.svh"

module ppfs_port_pin_select (
  input  wire logic                        sys_clk_i,
  input  wire logic                        resetn_i,
  // Configuration options, caught once after reset release
  input  wire logic [1:0]                  osc_mode_i,
  input  wire logic                        init_pin_sel_i,
  input  wire logic [1:0]                  rc_freq_sel_i,
  // Software control bits
  input  wire logic [`PPFS_IO_LINES-1:0]   io_dir_i,
  input  wire logic [`PPFS_IO_LINES-1:0]   io_data_i,
  input  wire logic [`PPFS_IO_LINES-1:0]   pull_en_i,
  input  wire logic [`PPFS_ALL_LINES-1:0]  wake_en_i,
  input  wire logic                        tone_en_i,
  input  wire logic                        tone_drive_out_i,
  // Pads
  input  wire logic [`PPFS_ALL_LINES-1:0]  pad_in_i,
  output logic [`PPFS_IO_LINES-1:0]        pad_out_o,
  output logic [`PPFS_IO_LINES-1:0]        pad_oe_o,
  output logic [`PPFS_IO_LINES-1:0]        pad_pull_o,
  // Core side
  output logic [`PPFS_ALL_LINES-1:0]       port_rd_o,
  output logic                             wake_o,
  output logic                             count_input_first_o,
  output logic                             count_input_second_o,
  output logic                             irq_n_o,
  output logic                             chip_init_n_o,
  output logic                             clock_pin_in_o,
  output logic [1:0]                       osc_own_o,
  output logic                             rc_osc_en_o,
  output logic [1:0]                       rc_freq_o
);

  ppfs_pkg::ppfs_state_type st;       // Registered state
  ppfs_pkg::ppfs_state_type next_st;  // Next state

  // Option values that steer the current cycle
  ppfs_pkg::ppfs_osc_type  osc_now;   // Oscillator option in force
  logic                    rst_now;   // Line 7 is the reset input
  logic                    run_now;   // Configuration captured
  logic                    own5;      // Line 5 taken by oscillator
  logic                    own6;      // Line 6 taken by oscillator
  logic [`PPFS_IO_LINES-1:0] own_vec; // Ownership per two-way line

  // Per-line results of the cells
  logic [`PPFS_IO_LINES-1:0] cell_oe;    // Driver enables
  logic [`PPFS_IO_LINES-1:0] cell_out;   // Drive levels
  logic [`PPFS_IO_LINES-1:0] cell_pull;  // Pull switches
  logic [`PPFS_IO_LINES-1:0] cell_wake;  // Wake arming
  logic [`PPFS_IO_LINES-1:0] alt_en;     // Shared output active
  logic [`PPFS_IO_LINES-1:0] alt_val;    // Shared output value
  logic [`PPFS_ALL_LINES-1:0] wake_arm;  // Arming incl. line 7
  logic [`PPFS_ALL_LINES-1:0] rd_mask;   // Lines readable as port

  assign run_now = (st.phase == ppfs_pkg::PPFS_RUN);
  assign osc_now = st.osc;
  assign rst_now = st.rst_pin;

  // oscillator pin map
  // Crystal and RC+RTC take both pins, external RC only line 6
  always_comb begin
    own5 = 1'b0;
    own6 = 1'b0;
    case (osc_now)
      ppfs_pkg::PPFS_OSC_RC_IO: begin
        own5 = 1'b0;
        own6 = 1'b0;
      end
      ppfs_pkg::PPFS_OSC_XTAL,
      ppfs_pkg::PPFS_OSC_RC_RTC: begin
        own5 = 1'b1;
        own6 = 1'b1;
      end
      ppfs_pkg::PPFS_OSC_EXT_RC: begin
        own5 = 1'b0;
        own6 = 1'b1;
      end
      default: begin
        own5 = 1'b0;
        own6 = 1'b0;
      end
    endcase
  end

  // Ownership vector; only lines 5 and 6 can be claimed
  always_comb begin
    own_vec = `PPFS_RST_IO;
    own_vec[`PPFS_LINE_OSC_OUT] = own5;
    own_vec[`PPFS_LINE_OSC_IN]  = own6;
  end

  // complementary tone pair
  // Tone reaches the pad only where the line is an output
  always_comb begin
    alt_en  = `PPFS_RST_IO;
    alt_val = `PPFS_RST_IO;
    alt_en[`PPFS_LINE_TONE_P]  = tone_en_i;
    alt_en[`PPFS_LINE_TONE_N]  = tone_en_i;
    alt_val[`PPFS_LINE_TONE_P] = tone_drive_out_i;
    alt_val[`PPFS_LINE_TONE_N] = ~tone_drive_out_i;
  end

  // One cell per two-way line
  genvar gi;
  generate
    for (gi = 0; gi < `PPFS_IO_LINES; gi = gi + 1) begin : g_line
      ppfs_line_cell u_cell (
        .dir_in_i   (io_dir_i[gi]),
        .data_i     (io_data_i[gi]),
        .pull_req_i (pull_en_i[gi]),
        .wake_req_i (wake_en_i[gi]),
        .alt_en_i   (alt_en[gi]),
        .alt_val_i  (alt_val[gi]),
        .osc_own_i  (own_vec[gi]),
        .run_i      (run_now),
        .oe_o       (cell_oe[gi]),
        .out_o      (cell_out[gi]),
        .pull_o     (cell_pull[gi]),
        .wake_arm_o (cell_wake[gi])
      );
    end
  endgenerate

  // line 7 input only
  // In reset mode line 7 is neither readable nor a wake source
  always_comb begin
    wake_arm = {(run_now & ~rst_now & wake_en_i[`PPFS_LINE_INIT]),
                cell_wake};
    rd_mask  = {(run_now & ~rst_now), (~own_vec & {7{run_now}})};
  end

  // Next-state logic for every registered output
  always_comb begin
    next_st = st;
    case (st.phase)
      // Options are caught once, the first edge after release
      ppfs_pkg::PPFS_LOAD: begin
        next_st.osc     = ppfs_pkg::ppfs_osc_type'(osc_mode_i);
        next_st.rst_pin = init_pin_sel_i;
        next_st.freq    = ppfs_pkg::ppfs_freq_type'(rc_freq_sel_i);
        next_st.phase   = ppfs_pkg::PPFS_RUN;
      end
      ppfs_pkg::PPFS_RUN: begin
        next_st.phase = ppfs_pkg::PPFS_RUN;
      end
      default: begin
        next_st.phase = ppfs_pkg::PPFS_LOAD;
      end
    endcase
    next_st.pad_oe  = cell_oe;
    next_st.pad_out = cell_out & cell_oe;
    next_st.pull    = cell_pull;
    // Port read shows pad levels, masked where not a port line
    next_st.rd      = pad_in_i & rd_mask;
    next_st.prev    = pad_in_i;
    // wake on change
    // Any armed line whose level moved raises a one-cycle wake
    next_st.wake    = |(wake_arm & (pad_in_i ^ st.prev));
    next_st.cnt_1st = run_now & pad_in_i[`PPFS_LINE_CNT_1ST];
    next_st.cnt_2nd = run_now & pad_in_i[`PPFS_LINE_CNT_2ND];
    // interrupt with I/O
    // Pin is watched whatever its direction; idle high
    next_st.irq_n   = ~run_now | pad_in_i[`PPFS_LINE_IRQ];
    next_st.init_n  = ~(run_now & rst_now) | pad_in_i[`PPFS_LINE_INIT];
    next_st.clk_in  = own6 & run_now & pad_in_i[`PPFS_LINE_OSC_IN];
    next_st.osc_own = {own6 & run_now, own5 & run_now};
    // internal RC frequency
    // RC runs in the internal modes; reserved code falls to 4 MHz
    next_st.rc_en   = run_now &
                      ((osc_now == ppfs_pkg::PPFS_OSC_RC_IO) ||
                       (osc_now == ppfs_pkg::PPFS_OSC_RC_RTC));
    next_st.freq    = (next_st.freq == ppfs_pkg::PPFS_FREQ_8M ||
                       next_st.freq == ppfs_pkg::PPFS_FREQ_12M) ?
                      next_st.freq : ppfs_pkg::PPFS_FREQ_4M;
  end

  // State register; constants only under reset
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st         <= '0;
      st.phase   <= ppfs_pkg::PPFS_LOAD;
      st.osc     <= ppfs_pkg::PPFS_OSC_RC_IO;
      st.freq    <= ppfs_pkg::PPFS_FREQ_4M;
      st.irq_n   <= `PPFS_RST_HIGH;
      st.init_n  <= `PPFS_RST_HIGH;
      st.rd      <= `PPFS_RST_ALL;
      st.pad_oe  <= `PPFS_RST_IO;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign pad_out_o            = st.pad_out;
  assign pad_oe_o             = st.pad_oe;
  assign pad_pull_o           = st.pull;
  assign port_rd_o            = st.rd;
  assign wake_o               = st.wake;
  assign count_input_first_o  = st.cnt_1st;
  assign count_input_second_o = st.cnt_2nd;
  assign irq_n_o              = st.irq_n;
  assign chip_init_n_o        = st.init_n;
  assign clock_pin_in_o       = st.clk_in;
  assign osc_own_o            = st.osc_own;
  assign rc_osc_en_o          = st.rc_en;
  assign rc_freq_o            = st.freq;

  // Checks against the registered outputs
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  // Running with a given oscillator option held for a cycle
  sequence osc_both_s;
    run_now && (osc_now == ppfs_pkg::PPFS_OSC_XTAL ||
                osc_now == ppfs_pkg::PPFS_OSC_RC_RTC);
  endsequence
  sequence osc_ext_rc_s;
    run_now && (osc_now == ppfs_pkg::PPFS_OSC_EXT_RC);
  endsequence

  dir_drive_a: assert property (
    run_now |=> (pad_oe_o == ($past(~io_dir_i) & ~$past(own_vec))))
    else $error("driver enable does not follow direction");

  wake_pulse_a: assert property (
    (run_now && wake_en_i[0] && !own_vec[0] &&
     (pad_in_i[0] != st.prev[0])) |=> wake_o)
    else $error("armed line change gave no wake");

  pull_gate_a: assert property (
    run_now |=> (pad_pull_o == ($past(pull_en_i) & ~$past(own_vec))))
    else $error("pull-high does not follow its bit");

  tone_pair_a: assert property (
    (run_now && tone_en_i && !io_dir_i[0] && !io_dir_i[1])
      |=> (pad_out_o[0] != pad_out_o[1]) && pad_oe_o[1:0] == 2'h3)
    else $error("tone pair not complementary");

  cnt_lines_a: assert property (
    run_now |=> (count_input_first_o == $past(pad_in_i[2])) &&
                (count_input_second_o == $past(pad_in_i[4])))
    else $error("counter inputs do not follow lines 2 and 4");

  irq_line_a: assert property (
    (run_now && !pad_in_i[3]) |=> !irq_n_o)
    else $error("low on line 3 gave no interrupt request");

  osc_map_a: assert property (
    osc_both_s ##1 osc_both_s |-> osc_own_o == 2'h3)
    else $error("oscillator option did not claim both lines");

  ext_rc_map_a: assert property (
    osc_ext_rc_s ##1 osc_ext_rc_s |-> osc_own_o == 2'h2)
    else $error("external RC claimed the wrong lines");

  rc_freq_a: assert property (
    run_now |=> rc_freq_o != 2'h3)
    else $error("reserved RC frequency code reached the output");

  init_line_a: assert property (
    (run_now && rst_now) |=> (chip_init_n_o == $past(pad_in_i[7]))
      && !port_rd_o[7])
    else $error("line 7 reset mode wrong");

  osc_isolate_a: assert property (
    osc_both_s |=> (pad_oe_o[6:5] == 2'h0) && (pad_pull_o[6:5] == 2'h0))
    else $error("oscillator line still driven or pulled");

endmodule

// [bench/ppfs_board_model.sv]
// Purpose: Board side of the port pads, resolving each line's level
// Assumes: Pads driven by the block, by a pull-high, or by the board
// Notes:   An undriven, unpulled line shows a random board level each cycle
`timescale 1ns/10ps

`include "ppfs_params.svh"

module ppfs_board_model (
  input  wire logic [`PPFS_IO_LINES-1:0]  pad_out_i,   // Block drive level
  input  wire logic [`PPFS_IO_LINES-1:0]  pad_oe_i,    // Block drive enable
  input  wire logic [`PPFS_IO_LINES-1:0]  pad_pull_i,  // Pull-high switch
  input  wire logic [`PPFS_ALL_LINES-1:0] board_i,     // Board levels
  output logic      [`PPFS_ALL_LINES-1:0] pad_in_o     // Resolved pad levels
);
  // Driver wins, then pull-high, then whatever the board puts there
  always_comb begin
    for (int i = 0; i < `PPFS_IO_LINES; i++) begin
      if (pad_oe_i[i]) begin
        pad_in_o[i] = pad_out_i[i];
      end else if (pad_pull_i[i]) begin
        pad_in_o[i] = 1'b1;
      end else begin
        pad_in_o[i] = board_i[i];
      end
    end
    // Input-only line is never driven by the block
    pad_in_o[`PPFS_LINE_INIT] = board_i[`PPFS_LINE_INIT];
  end
endmodule

// [bench/ppfs_port_pin_select_bench.sv]
// Purpose: Self-checking bench of the port pin function select block
// Assumes: One-cycle latency from inputs to registered outputs
// Notes:   Reference model recomputes every output from input snapshots
`timescale 1ns/10ps

`include "ppfs_params.svh"

`define PPFS_CHECK(act, exp) begin tests_run++; if ((act) !== (exp)) begin \
  n_fail++; $display("CHECK FAILED t=%0t act=%h exp=%h", $time, act, exp); \
  end end

module port_pin_function_select_bench;
  logic                        sys_clk_i = 1'b0;   // 250 MHz clock
  logic                        resetn_i  = 1'b0;   // Active-low reset
  logic [1:0]                  osc_mode, rc_sel;   // Option inputs
  logic                        init_sel;           // Line 7 option
  logic [`PPFS_IO_LINES-1:0]   dir, data, pull_en; // Software bits
  logic [`PPFS_ALL_LINES-1:0]  wake_en, board;     // Wake bits, board
  logic                        tone_en, tone;      // Buzzer controls
  logic [`PPFS_ALL_LINES-1:0]  pad_in;             // Resolved pads
  logic [`PPFS_IO_LINES-1:0]   pad_out, pad_oe, pad_pull;
  logic [`PPFS_ALL_LINES-1:0]  rd;
  logic                        wake, cnt1, cnt2, irq_n, init_n, clk_in;
  logic                        rc_en;
  logic [1:0]                  own, freq;
  // Snapshots of inputs before the sampling edge, and captured options
  logic [`PPFS_IO_LINES-1:0]   s_dir, s_data, s_pull, ownv, exp_oe, tv;
  logic [`PPFS_ALL_LINES-1:0]  s_wake, s_pad, p_pad, arm;
  logic                        s_ten, s_tone, c_init;
  logic [1:0]                  c_mode, c_sel, exp_own;
  integer                      seed = 32'h50c2c238;
  int                          n_fail = 0;
  int                          tests_run = 0;

  // Free-running clock, 4 ns period
  always #2 sys_clk_i = ~sys_clk_i;

  ppfs_port_pin_select ppfs_port_pin_select_i (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .osc_mode_i(osc_mode),
    .init_pin_sel_i(init_sel), .rc_freq_sel_i(rc_sel), .io_dir_i(dir),
    .io_data_i(data), .pull_en_i(pull_en), .wake_en_i(wake_en),
    .tone_en_i(tone_en), .tone_drive_out_i(tone), .pad_in_i(pad_in),
    .pad_out_o(pad_out), .pad_oe_o(pad_oe), .pad_pull_o(pad_pull),
    .port_rd_o(rd), .wake_o(wake), .count_input_first_o(cnt1),
    .count_input_second_o(cnt2), .irq_n_o(irq_n), .chip_init_n_o(init_n),
    .clock_pin_in_o(clk_in), .osc_own_o(own), .rc_osc_en_o(rc_en),
    .rc_freq_o(freq));

  ppfs_board_model ppfs_board_model_i (
    .pad_out_i(pad_out), .pad_oe_i(pad_oe), .pad_pull_i(pad_pull),
    .board_i(board), .pad_in_o(pad_in));

  // Closing verdict, reached from the main sequence or the watchdog
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Fresh random values on every control and board input
  task automatic drive_random();
    {dir, data, pull_en} = {$random(seed), $random(seed)};
    {wake_en, board, tone_en, tone} = $random(seed);
  endtask

  // Compare every output with the model, from last cycle's snapshot
  task automatic check_cycle(input bit with_wake);
    exp_own = (c_mode == 2'b00) ? 2'b00 : (c_mode == 2'b11) ? 2'b10 : 2'b11;
    ownv = {exp_own, 5'h00};
    // Output lines drive, input lines float
    exp_oe = ~s_dir & ~ownv;
    tv = s_data;
    if (s_ten) begin
      tv[`PPFS_LINE_TONE_P] = s_tone;
      tv[`PPFS_LINE_TONE_N] = ~s_tone;
    end
    arm = s_wake & {~c_init, ~ownv};
    `PPFS_CHECK(own, exp_own)
    `PPFS_CHECK(pad_oe, exp_oe)
    `PPFS_CHECK(pad_out, tv & exp_oe)
    `PPFS_CHECK(pad_pull, s_pull & ~ownv)
    `PPFS_CHECK(rd, {s_pad[7] & ~c_init, s_pad[6:0] & ~ownv})
    `PPFS_CHECK(cnt1, s_pad[`PPFS_LINE_CNT_1ST])
    `PPFS_CHECK(irq_n, s_pad[`PPFS_LINE_IRQ])
    `PPFS_CHECK(cnt2, s_pad[`PPFS_LINE_CNT_2ND])
    `PPFS_CHECK(init_n, c_init ? s_pad[7] : 1'b1)
    `PPFS_CHECK(clk_in, exp_own[1] & s_pad[`PPFS_LINE_OSC_IN])
    `PPFS_CHECK(rc_en, ~c_mode[0])
    `PPFS_CHECK(freq, (c_sel == 2'b11) ? 2'b00 : c_sel)
    if (with_wake) begin
      `PPFS_CHECK(wake, |(arm & (s_pad ^ p_pad)))
    end
  endtask

  // Watchdog cuts a hang well beyond the expected run length
  initial begin
    #40000;
    n_fail++;
    finish_test();
  end

  // Main sequence: one reset and random run for each of four option settings
  initial begin
    {osc_mode, rc_sel, init_sel} = 5'h00;
    drive_random();
    for (int k = 0; k < 4; k++) begin
      resetn_i = 1'b0;
      repeat (10) @(posedge sys_clk_i);
      #1;
      // Held in reset: no drive, no pull, no read, request lines idle
      `PPFS_CHECK({pad_oe, pad_pull, rd, wake, irq_n, init_n}, {7'h00, 7'h00, 8'h00, 1'b0, 2'h3})
      osc_mode = k[1:0];
      rc_sel   = k[1:0];
      init_sel = k[0];
      {c_mode, c_sel, c_init} = {osc_mode, rc_sel, init_sel};
      resetn_i = 1'b1;
      // Capture edge keeps outputs other than rc_freq_o in their reset state
      @(posedge sys_clk_i);
      #1;
      `PPFS_CHECK({pad_oe, irq_n, init_n}, {7'h00, 2'h3})
      s_pad = pad_in;
      for (int n = 0; n < 200; n++) begin
        // Options changing after capture must be ignored
        if (n == 100) begin
          {osc_mode, rc_sel, init_sel} = ~{osc_mode, rc_sel, init_sel};
        end
        drive_random();
        #1;
        p_pad = s_pad;
        {s_dir, s_data, s_pull} = {dir, data, pull_en};
        {s_wake, s_ten, s_tone, s_pad} = {wake_en, tone_en, tone, pad_in};
        @(posedge sys_clk_i);
        #1;
        check_cycle(n > 1);
      end
      $display("Test with option %0d done, mismatches %0d", k, n_fail);
    end
    finish_test();
  end
endmodule
